// ==== design/sep_pkg.sv ====
/*
 * constants, state type and timing counts shared by the serial eeprom slave
 * assumes a single 200 MHz system clock and no register bus
 */
package sep_pkg;
    // ****************************************************************
    // variant selection and pin vector layout
    // ****************************************************************
    localparam logic [1:0] SEP_VAR_1K = 2'h0;
    localparam logic [1:0] SEP_VAR_2K = 2'h1;
    localparam logic [1:0] SEP_VAR_4K = 2'h2;
    localparam int SEP_NPIN = 6;
    localparam int SEP_PIN_SCL = 0;
    localparam int SEP_PIN_SDA = 1;
    localparam int SEP_PIN_WP = 2;
    localparam int SEP_PIN_STRAP_LOW = 3;
    localparam int SEP_PIN_STRAP_MID = 4;
    localparam int SEP_PIN_STRAP_HIGH = 5;
    localparam logic [5:0] SEP_PIN_RST = 6'h3F;
    // ****************************************************************
    // address layout
    // ****************************************************************
    localparam logic [3:0] SEP_DEV_TYPE = 4'h5; // arbitrary value
    localparam logic [8:0] SEP_AMASK_1K = 9'h07F;
    localparam logic [8:0] SEP_AMASK_2K = 9'h0FF;
    localparam logic [8:0] SEP_AMASK_4K = 9'h1FF;
    localparam logic [8:0] SEP_PMASK_8 = 9'h007;
    localparam logic [8:0] SEP_PMASK_16 = 9'h00F;
    localparam logic [8:0] SEP_ONE = 9'h001;
    localparam logic [7:0] SEP_ERASED = 8'hFF;
    localparam logic [2:0] SEP_BIT_LAST = 3'h7;
    localparam int SEP_DEPTH = 512;
    localparam int SEP_PAGE_MAX = 16;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int SEP_T_WR_MS = 10;
    localparam int SEP_CLK_KHZ = 200000;
    localparam int SEP_WR_CYCLES = SEP_T_WR_MS * SEP_CLK_KHZ;
    localparam int SEP_TMR_W = 22;
    // ****************************************************************
    // protocol engine states
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WADDR, ST_WDATA,
        ST_ACK_BYTE, ST_RDATA, ST_RACK, ST_IGNORE
    } sep_state_t;
endpackage

// ==== design/sep_bus_if.sv ====
/*
 * filtered pin levels and bus events passed from the pin front end to the engine
 * assumes both ends run on clk_sys_i
 */
`timescale 1ns/1ps
interface sep_bus_if;
    logic [5:0] lvl;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    modport front (output lvl, scl_rise, scl_fall, start, stop);
    modport engine (input lvl, scl_rise, scl_fall, start, stop);
endinterface

// ==== design/sep_pin_front.sv ====
/*
 * three-stage pin synchronisers with agreement filter, and bus event detection
 * assumes pins are asynchronous to clk_sys_i and change far slower than it
 */
`timescale 1ns/1ps
module sep_pin_front
    import sep_pkg::*;
(
    input wire logic clk_sys_i,                 // system clock
    input wire logic rst_i,                     // synchronous reset, active high
    input wire logic [SEP_NPIN-1:0] pins_i,     // raw pin levels
    sep_bus_if.front bus                        // filtered levels and events
);
    typedef struct packed {
        logic [SEP_NPIN-1:0] s0;
        logic [SEP_NPIN-1:0] s1;
        logic [SEP_NPIN-1:0] s2;
        logic [SEP_NPIN-1:0] lvl;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } sep_front_t;

    localparam sep_front_t FRONT_RST = '{s0: SEP_PIN_RST, s1: SEP_PIN_RST, s2: SEP_PIN_RST,
                                         lvl: SEP_PIN_RST, default: '0};

    sep_front_t front_reg;
    sep_front_t front_next;

    // ****************************************************************
    // filter and edge detection
    // ****************************************************************
    // a level moves only once stages two and three agree; stage one feeds stage two only
    always_comb begin
        front_next = front_reg;
        front_next.s0 = pins_i;
        front_next.s1 = front_reg.s0;
        front_next.s2 = front_reg.s1;
        for (int i = 0; i < SEP_NPIN; i++) begin
            if (front_reg.s1[i] == front_reg.s2[i]) begin
                front_next.lvl[i] = front_reg.s2[i];
            end
        end
        front_next.scl_rise = !front_reg.lvl[SEP_PIN_SCL] && front_next.lvl[SEP_PIN_SCL];
        front_next.scl_fall = front_reg.lvl[SEP_PIN_SCL] && !front_next.lvl[SEP_PIN_SCL];
        // sda moving while scl stays high frames a command
        front_next.start = front_reg.lvl[SEP_PIN_SCL] && front_next.lvl[SEP_PIN_SCL] &&
                           front_reg.lvl[SEP_PIN_SDA] && !front_next.lvl[SEP_PIN_SDA];
        front_next.stop = front_reg.lvl[SEP_PIN_SCL] && front_next.lvl[SEP_PIN_SCL] &&
                          !front_reg.lvl[SEP_PIN_SDA] && front_next.lvl[SEP_PIN_SDA];
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            front_reg <= FRONT_RST;
        end else begin
            front_reg <= front_next;
        end
    end

    assign bus.lvl = front_reg.lvl;
    assign bus.scl_rise = front_reg.scl_rise;
    assign bus.scl_fall = front_reg.scl_fall;
    assign bus.start = front_reg.start;
    assign bus.stop = front_reg.stop;
endmodule

// ==== design/sep_eeprom_slave.sv ====
/*
 * two-wire serial eeprom slave: addressing, acknowledge, page buffer, array, reads
 * assumes an external master drives scl, an outside pull-up resolves sda
 */
// What this block does
// (RULE_01) write buffer reaches array only at stop
// (RULE_02) master sends slave address right after start
// (RULE_03) upper four address bits match device type
// (RULE_04) small variants compare three strap bits
// (RULE_05) large variant compares two upper straps
// (RULE_06) large variant half select picks array half
// (RULE_07) address lsb: zero writes, one reads
// (RULE_08) write protect high blocks all programming
// (RULE_09) receiver pulls data low on ninth clock
// (RULE_10) transmitter releases data after eight bits
// (RULE_11) master ack low means send next byte
// (RULE_12) no ack: release line, idle at stop
// (RULE_13) byte write lands at received word address
// (RULE_14) small variant pages hold eight bytes
// (RULE_15) mid variant pages hold eight bytes
// (RULE_16) large variant pages hold sixteen bytes
// (RULE_17) after reads counter is last plus one
// (RULE_18) after writes counter stays at last written
// (RULE_19) random read: set address, restart, read
// (RULE_20) master ends read with nack then stop
// (RULE_21) sequential reads run through whole array
// (RULE_22) array starts with every byte erased
// (RULE_23) master holds lines high during power rise
// (RULE_24) start is sda falling with scl high
// (RULE_25) stop is sda rising with scl high
// (RULE_26) sample on scl rise, drive after fall
// (RULE_27) programming cycle ends within ten ms
// (RULE_28) extra page bytes wrap and overwrite
// (RULE_29) no address ack while programming
`timescale 1ns/1ps
module sep_eeprom_slave
    import sep_pkg::*;
#(
    parameter int WR_CYCLES = SEP_WR_CYCLES,    // programming cycle length
    parameter logic [1:0] VARIANT = SEP_VAR_4K  // array size variant
) (
    input wire logic clk_sys_i,         // system clock
    input wire logic rst_i,             // synchronous reset, active high
    input wire logic scl_i,             // serial clock pin
    input wire logic sda_i,             // serial data pin level
    input wire logic strap_bit_low_i,   // address strap, lowest
    input wire logic strap_bit_mid_i,   // address strap, middle
    input wire logic strap_bit_high_i,  // address strap, highest
    input wire logic wp_i,              // write protect pin
    output logic sda_o,                 // sda output value, always low
    output logic sda_oe_n_o,            // low while pulling sda low
    output logic busy_o                 // programming cycle running
);
    typedef struct packed {
        sep_state_t st;
        logic [2:0] bitcnt;
        logic got;
        logic [7:0] shift;
        logic rd;
        logic hsel;
        logic [8:0] waddr;
        logic [8:0] ac;
        logic [SEP_PAGE_MAX-1:0][7:0] pbuf;
        logic [SEP_PAGE_MAX-1:0] pval;
        logic mack;
        logic oe_n;
        logic sda_out;
        logic busy;
        logic [SEP_TMR_W-1:0] tmr;
        logic [SEP_DEPTH-1:0][7:0] mem;
    } sep_core_t;

    // erased array, idle bus, no transfer pending
    localparam sep_core_t CORE_RST = '{st: ST_IDLE, oe_n: 1'b1, mack: 1'b1,
                                       mem: {SEP_DEPTH{SEP_ERASED}}, default: '0}; // [RULE_22]
    localparam logic [SEP_TMR_W-1:0] TMR_LOAD = SEP_TMR_W'(WR_CYCLES - 1);
    localparam logic [SEP_TMR_W-1:0] TMR_ZERO = '0;

    sep_core_t core_reg;
    sep_core_t core_next;
    sep_bus_if bus ();
    logic [8:0] amask;
    logic [8:0] pmask;
    logic [2:0] straps;
    logic sda_lvl;

    // ****************************************************************
    // decoding helpers
    // ****************************************************************
    // array size mask per variant
    function automatic logic [8:0] array_mask(input logic [1:0] v);
        unique case (v)
            SEP_VAR_1K: array_mask = SEP_AMASK_1K;
            SEP_VAR_2K: array_mask = SEP_AMASK_2K;
            default: array_mask = SEP_AMASK_4K;
        endcase
    endfunction

    // low address bits that roll inside one page
    function automatic logic [8:0] page_mask(input logic [1:0] v);
        page_mask = (v == SEP_VAR_4K) ? SEP_PMASK_16 : SEP_PMASK_8; // [RULE_14] [RULE_15] [RULE_16]
    endfunction

    // slave address byte compare; the 4k part skips the lowest strap
    function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] s, input logic [1:0] v);
        addr_hit = (b[7:4] == SEP_DEV_TYPE); // [RULE_03]
        if (v == SEP_VAR_4K) begin
            addr_hit = addr_hit && (b[3:2] == s[2:1]); // [RULE_05]
        end else begin
            addr_hit = addr_hit && (b[3:1] == s); // [RULE_04]
        end
    endfunction

    // word address byte plus the half select bit, cut to the array size
    function automatic logic [8:0] word_addr(input logic [7:0] b, input logic h, input logic [1:0] v);
        word_addr = {h, b} & array_mask(v); // [RULE_06]
    endfunction

    assign amask = array_mask(VARIANT);
    assign pmask = page_mask(VARIANT);
    assign straps = bus.lvl[SEP_PIN_STRAP_HIGH:SEP_PIN_STRAP_LOW];
    assign sda_lvl = bus.lvl[SEP_PIN_SDA];

    // ****************************************************************
    // pin front end
    // ****************************************************************
    sep_pin_front u_front (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pins_i({strap_bit_high_i, strap_bit_mid_i, strap_bit_low_i, wp_i, sda_i, scl_i}),
        .bus(bus.front)
    );

    // ****************************************************************
    // protocol engine
    // ****************************************************************
    // start and stop outrank clock edges, since they only occur with scl high
    always_comb begin
        core_next = core_reg;
        core_next.sda_out = 1'b0;
        // programming timer; the address is not acked until it expires
        if (core_reg.busy) begin
            if (core_reg.tmr == TMR_ZERO) begin
                core_next.busy = 1'b0; // [RULE_27]
            end else begin
                core_next.tmr = core_reg.tmr - 1'b1;
            end
        end
        if (bus.stop) begin
            // buffered bytes are committed here and nowhere else
            if (|core_reg.pval && !core_reg.busy && !bus.lvl[SEP_PIN_WP]) begin // [RULE_01] [RULE_08]
                for (int i = 0; i < SEP_PAGE_MAX; i++) begin
                    if (core_reg.pval[i]) begin
                        core_next.mem[(core_reg.waddr & ~pmask) | 9'(i)] = core_reg.pbuf[i]; // [RULE_13]
                    end
                end
                core_next.busy = 1'b1;
                core_next.tmr = TMR_LOAD;
            end
            core_next.st = ST_IDLE; // [RULE_25] [RULE_12]
            core_next.oe_n = 1'b1;
            core_next.pval = '0;
            core_next.got = 1'b0;
        end else if (bus.start) begin
            // a repeated start drops an uncommitted page, nothing is programmed
            core_next.st = ST_ADDR; // [RULE_24] [RULE_02]
            core_next.bitcnt = '0;
            core_next.got = 1'b0;
            core_next.oe_n = 1'b1;
            core_next.pval = '0;
        end else if (bus.scl_rise) begin
            // incoming bits are taken on the rising edge
            if (core_reg.st inside {ST_ADDR, ST_WADDR, ST_WDATA}) begin // [RULE_26]
                core_next.shift = {core_reg.shift[6:0], sda_lvl};
                core_next.bitcnt = core_reg.bitcnt + 1'b1;
                core_next.got = (core_reg.bitcnt == SEP_BIT_LAST);
            end
            if (core_reg.st == ST_RACK) begin
                core_next.mack = sda_lvl; // [RULE_11]
            end
        end else if (bus.scl_fall) begin
            // outgoing levels only move after the falling edge
            unique case (core_reg.st)
                ST_ADDR: begin
                    if (core_reg.got) begin
                        core_next.got = 1'b0;
                        if (addr_hit(core_reg.shift, straps, VARIANT) && !core_reg.busy) begin // [RULE_29]
                            core_next.st = ST_ACK_ADDR;
                            core_next.oe_n = 1'b0; // [RULE_09]
                            core_next.rd = core_reg.shift[0]; // [RULE_07]
                            core_next.hsel = (VARIANT == SEP_VAR_4K) && core_reg.shift[1]; // [RULE_06]
                        end else begin
                            core_next.st = ST_IGNORE;
                        end
                    end
                end
                ST_WADDR, ST_WDATA: begin
                    if (core_reg.got) begin
                        core_next.got = 1'b0;
                        core_next.st = ST_ACK_BYTE;
                        core_next.oe_n = 1'b0; // [RULE_09]
                        if (core_reg.st == ST_WADDR) begin
                            // also sets the pointer used by a following random read
                            core_next.waddr = word_addr(core_reg.shift, core_reg.hsel, VARIANT); // [RULE_19]
                            core_next.ac = core_next.waddr;
                        end else begin
                            // low bits roll inside the page; a repeat overwrites
                            core_next.pbuf[core_reg.waddr[3:0] & pmask[3:0]] = core_reg.shift; // [RULE_28]
                            core_next.pval[core_reg.waddr[3:0] & pmask[3:0]] = 1'b1;
                            core_next.ac = core_reg.waddr; // [RULE_18]
                            core_next.waddr = (core_reg.waddr & ~pmask) |
                                              ((core_reg.waddr + SEP_ONE) & pmask); // [RULE_14] [RULE_15] [RULE_16]
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    core_next.bitcnt = '0;
                    if (core_reg.rd) begin
                        core_next.shift = core_reg.mem[core_reg.ac];
                        core_next.oe_n = core_reg.mem[core_reg.ac][7];
                        core_next.st = ST_RDATA;
                    end else begin
                        core_next.oe_n = 1'b1;
                        core_next.st = ST_WADDR;
                    end
                end
                ST_ACK_BYTE: begin
                    core_next.oe_n = 1'b1;
                    core_next.bitcnt = '0;
                    core_next.st = ST_WDATA;
                end
                ST_RDATA: begin
                    if (core_reg.bitcnt == SEP_BIT_LAST) begin
                        // line released for the master's answer
                        core_next.oe_n = 1'b1; // [RULE_10]
                        core_next.st = ST_RACK;
                        core_next.ac = (core_reg.ac + SEP_ONE) & amask; // [RULE_17] [RULE_21]
                    end else begin
                        core_next.shift = {core_reg.shift[6:0], 1'b0};
                        core_next.oe_n = core_reg.shift[6];
                        core_next.bitcnt = core_reg.bitcnt + 1'b1;
                    end
                end
                ST_RACK: begin
                    if (!core_reg.mack) begin
                        core_next.shift = core_reg.mem[core_reg.ac]; // [RULE_11] [RULE_21]
                        core_next.oe_n = core_reg.mem[core_reg.ac][7];
                        core_next.bitcnt = '0;
                        core_next.st = ST_RDATA;
                    end else begin
                        core_next.oe_n = 1'b1; // [RULE_12] [RULE_20]
                        core_next.st = ST_IGNORE;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    core_next.oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            core_reg <= CORE_RST;
        end else begin
            core_reg <= core_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign sda_o = core_reg.sda_out;
    assign sda_oe_n_o = core_reg.oe_n;
    assign busy_o = core_reg.busy;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    property p_commit_at_stop;
        !$stable(core_reg.mem) |-> $past(bus.stop);
    endproperty
    a_commit_at_stop: assert property (p_commit_at_stop) // [RULE_01]
        else $error("array changed without a stop");

    property p_wp_blocks;
        $past(bus.lvl[SEP_PIN_WP]) |-> $stable(core_reg.mem);
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) // [RULE_08]
        else $error("array written while protected");

    property p_busy_no_ack;
        $rose(core_reg.st == ST_ACK_ADDR) |-> $past(!core_reg.busy) && !sda_oe_n_o;
    endproperty
    a_busy_no_ack: assert property (p_busy_no_ack) // [RULE_29]
        else $error("address acked while programming");

    property p_ack_low;
        (core_reg.st inside {ST_ACK_ADDR, ST_ACK_BYTE}) |-> !sda_oe_n_o;
    endproperty
    a_ack_low: assert property (p_ack_low) // [RULE_09]
        else $error("ack slot not driven low");

    property p_release_answer;
        (core_reg.st == ST_RACK) |-> sda_oe_n_o;
    endproperty
    a_release_answer: assert property (p_release_answer) // [RULE_10]
        else $error("sda held during master answer");

    property p_start_addr;
        bus.start && !bus.stop |=> core_reg.st == ST_ADDR && sda_oe_n_o;
    endproperty
    a_start_addr: assert property (p_start_addr) // [RULE_24]
        else $error("start not followed by address phase");

    property p_stop_idle;
        bus.stop |=> core_reg.st == ST_IDLE && sda_oe_n_o;
    endproperty
    a_stop_idle: assert property (p_stop_idle) // [RULE_25]
        else $error("stop did not return to idle");

    property p_nack_ends;
        core_reg.st == ST_RACK && core_reg.mack && bus.scl_fall && !bus.stop
            |=> core_reg.st == ST_IGNORE ##1 sda_oe_n_o;
    endproperty
    a_nack_ends: assert property (p_nack_ends) // [RULE_12]
        else $error("read continued after nack");

    property p_drive_after_fall;
        !$stable(sda_oe_n_o) |-> $past(bus.scl_fall) || $past(bus.start) || $past(bus.stop);
    endproperty
    a_drive_after_fall: assert property (p_drive_after_fall) // [RULE_26]
        else $error("sda changed away from a falling edge");

    property p_read_advance;
        $rose(core_reg.st == ST_RACK) |-> core_reg.ac == (($past(core_reg.ac) + SEP_ONE) & amask);
    endproperty
    a_read_advance: assert property (p_read_advance) // [RULE_17]
        else $error("read pointer not advanced by one");

    property p_timer_runs;
        core_reg.busy && core_reg.tmr != TMR_ZERO |=> core_reg.busy && core_reg.tmr == $past(core_reg.tmr) - 1'b1;
    endproperty
    a_timer_runs: assert property (p_timer_runs) // [RULE_27]
        else $error("programming timer stalled");

    c_program: cover property ($rose(core_reg.busy));
    c_seq_read: cover property (core_reg.st == ST_RACK && !core_reg.mack && bus.scl_fall);
    c_busy_poll: cover property (core_reg.busy && core_reg.st == ST_IGNORE);
    c_page_wrap: cover property (&core_reg.pval);
endmodule

// ==== verification/sep_master_model.sv ====
/* two-wire bus master model driving the serial clock and the data line
   assumes an outside pull-up on data and a 200 MHz bench clock */
`timescale 1ns/1ps
module sep_master_model (
    input wire logic clk_sys_i, // bench clock
    input wire logic sda_i,     // resolved data wire
    output logic scl_o,         // serial clock
    output logic sda_o          // 1 releases the wire
);
    localparam int H = 16; // a third of a bit, far above the pin filter delay
    // both lines idle high from time zero
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic hw();
        repeat (H) @(negedge clk_sys_i);
    endtask
    // data falls while clock high, also used as repeated start
    task automatic start();
        sda_o = 1'b1;
        hw();
        scl_o = 1'b1;
        hw();
        sda_o = 1'b0;
        hw();
        scl_o = 1'b0;
    endtask
    // data rises while clock high
    task automatic stop();
        sda_o = 1'b0;
        hw();
        scl_o = 1'b1;
        hw();
        sda_o = 1'b1;
        hw();
    endtask
    // set while clock low, sample at the end of clock high, just before it falls
    task automatic bit_io(input logic b, output logic s);
        sda_o = b;
        hw();
        scl_o = 1'b1;
        hw();
        s = sda_i;
        scl_o = 1'b0;
        hw();
    endtask
    // msb first, then ninth clock; d of all ones releases the line
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ai, ack);
    endtask
endmodule

// ==== verification/sep_eeprom_slave_test.sv ====
/* self-checking bench for the serial eeprom slave, 4k variant
   assumes the master model beside it and a pull-up on the data wire */
`timescale 1ns/1ps
module sep_eeprom_slave_test import sep_pkg::*; ;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic wp_i = 1'b0;
    logic scl, mst_sda, sda_o, sda_oe_n_o, busy_o, ack;
    logic [7:0] q;
    logic [7:0] img [0:511]; // expected array contents
    int n_fail = 0;
    int total_checks = 0;
    // pull-up wins unless a party pulls low
    wire sda_w = mst_sda & (sda_oe_n_o ? 1'b1 : sda_o);
    sep_eeprom_slave #(.WR_CYCLES(2000), .VARIANT(SEP_VAR_4K)) sep_eeprom_slave_inst (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
        .strap_bit_low_i(1'b1), .strap_bit_mid_i(1'b0), .strap_bit_high_i(1'b1), .wp_i(wp_i),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o));
    sep_master_model sep_master_model_inst (
        .clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_o(mst_sda));
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] sa(input logic [1:0] st, input logic hf, input logic rw);
        return {SEP_DEV_TYPE, st, hf, rw};
    endfunction
    // start then slave address, expected ack level ea
    task automatic addr(input logic [7:0] b, input logic [7:0] ea);
        sep_master_model_inst.start();
        sep_master_model_inst.xfer(b, 1'b1, q, ack);
        chk("addr ack", ea, {7'h0, ack});
    endtask
    // set the word pointer without a stop
    task automatic seta(input logic hf, input logic [7:0] wa);
        addr(sa(2'b10, hf, 1'b0), 8'h0);
        sep_master_model_inst.xfer(wa, 1'b1, q, ack);
        chk("word ack", 8'h0, {7'h0, ack});
    endtask
    // n bytes from wa, low bits wrap inside the 16-byte page
    task automatic wr(input logic hf, input logic [7:0] wa, input int n, input logic [7:0] d0);
        seta(hf, wa);
        for (int k = 0; k < n; k++) begin
            sep_master_model_inst.xfer(d0 + 8'(k), 1'b1, q, ack);
            if (!wp_i) img[{hf, wa[7:4], 4'(wa[3:0] + k)}] = d0 + 8'(k);
        end
        chk("data ack", 8'h0, {7'h0, ack});
        sep_master_model_inst.stop();
        chk("busy", {7'h0, !wp_i}, {7'h0, busy_o});
    endtask
    // read n bytes, ack all but the last, nack then stop
    task automatic rd(input logic hf, input logic [8:0] a, input int n);
        addr(sa(2'b10, hf, 1'b1), 8'h0);
        for (int k = 0; k < n; k++) begin
            sep_master_model_inst.xfer(8'hFF, k == n - 1, q, ack);
            chk("read", img[9'(a + k)], q);
        end
        sep_master_model_inst.stop();
    endtask
    task automatic idle();
        int t;
        t = 0;
        while (busy_o !== 1'b0 && t < 3000) begin
            @(negedge clk_sys_i);
            t++;
        end
        chk("busy end", 8'h0, {7'h0, busy_o});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        for (int i = 0; i < 512; i++)
            img[i] = 8'hFF;
        repeat (8) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        addr({SEP_DEV_TYPE ^ 4'h3, 4'h8}, 8'h1);
        sep_master_model_inst.stop();
        addr(sa(2'b11, 1'b0, 1'b0), 8'h1);
        sep_master_model_inst.stop();
        wr(1'b1, 8'h12, 1, 8'hA5);
        addr(sa(2'b10, 1'b1, 1'b1), 8'h1);
        sep_master_model_inst.stop();
        idle();
        rd(1'b1, 9'h112, 1);
        seta(1'b0, 8'h12);
        rd(1'b0, 9'h012, 2);
        rd(1'b0, 9'h014, 1);
        wr(1'b0, 8'h1E, 17, 8'h30);
        idle();
        rd(1'b0, 9'h01E, 1);
        seta(1'b0, 8'h10);
        rd(1'b0, 9'h010, 15);
        rd(1'b0, 9'h01F, 1);
        wp_i = 1'b1;
        wr(1'b0, 8'h40, 1, 8'h77);
        wp_i = 1'b0;
        seta(1'b0, 8'h40);
        rd(1'b0, 9'h040, 1);
        seta(1'b0, 8'h50);
        sep_master_model_inst.xfer(8'h66, 1'b1, q, ack);
        seta(1'b0, 8'h50);
        rd(1'b0, 9'h050, 1);
        conclude();
    end
    // watchdog well beyond the expected run
    initial begin
        repeat (100000) @(negedge clk_sys_i);
        n_fail++;
        conclude();
    end
endmodule
